// File: hdl/sbw_pkg.sv
// Purpose: shared constants, encodings and helpers for the system bus
// Assumes: one master clock shared by the device end and the agent end
// Notes: command codes and identifier bit positions are fixed here only
package sbw_pkg;
  // bus widths
  localparam int AD_W = 32;
  localparam int CMD_W = 9;
  localparam int LEN_W = 4;
  // single/block write flow-control mode field of the config input
  localparam int CFG_W = 3;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_MODE_MSB = 2;
  typedef enum logic [1:0] {
    WMODE_LEGACY = 2'h0,
    WMODE_RSVD = 2'h1,
    WMODE_PIPE = 2'h2,
    WMODE_REISSUE = 2'h3
  } sbw_wmode_type;
  localparam logic [1:0] CFG_MODE_RESET = 2'h0;
  // timing counts in master clock cycles
  localparam int WRITE_READY_LAG = 2;
  localparam int DUMMY_CYCLES = 2;
  localparam int AGENT_DRIVE_DELAY = 2;
  localparam int EXTRQ_DROP_DELAY = 2;
  // command bus layout: bit 8 tells data identifier from command
  localparam int CMD_DATA_BIT = 8;
  localparam int CMD_CODE_MSB = 7;
  localparam int CMD_CODE_LSB = 5;
  localparam int ID_FINAL_BIT = 7;
  localparam int ID_RESP_BIT = 6;
  localparam int ID_ERR_BIT = 5;
  // command codes
  localparam logic [2:0] CODE_READ = 3'h0;
  localparam logic [2:0] CODE_WRITE = 3'h2;
  localparam logic [2:0] CODE_NULL = 3'h3;
  // reserved command bits are sent as ones
  localparam logic [4:0] CMD_RSVD = 5'h1f;
  localparam logic [4:0] ID_RSVD = 5'h1f;

  // build a request command word
  function automatic logic [CMD_W-1:0] mk_cmd(input logic [2:0] code);
    mk_cmd = {1'b0, code, CMD_RSVD};
  endfunction : mk_cmd

  // build a data identifier word
  function automatic logic [CMD_W-1:0] mk_id(input logic fin,
                                             input logic resp,
                                             input logic err);
    mk_id = {1'b1, fin, resp, err, ID_RSVD};
  endfunction : mk_id

  // true when a command word carries the given code
  function automatic logic is_code(input logic [CMD_W-1:0] c,
                                   input logic [2:0] code);
    is_code = !c[CMD_DATA_BIT] && (c[CMD_CODE_MSB:CMD_CODE_LSB] == code);
  endfunction : is_code
endpackage : sbw_pkg

// File: hdl/sbw_bus_if.sv
// Purpose: shared address/data and command wires between the two ends
// Assumes: at most one end enables its drivers in any cycle
// Notes: the resolved level is worked out here from the enables
interface sbw_bus_if (
  // master clock
  input wire logic clk
);
  // device drivers
  logic [sbw_pkg::AD_W-1:0] dev_ad;
  logic [sbw_pkg::CMD_W-1:0] dev_cmd;
  logic dev_oe;
  // agent drivers
  logic [sbw_pkg::AD_W-1:0] agt_ad;
  logic [sbw_pkg::CMD_W-1:0] agt_cmd;
  logic agt_oe;
  // resolved buses
  logic [sbw_pkg::AD_W-1:0] shared_addr_data_bus;
  logic [sbw_pkg::CMD_W-1:0] command_bus;
  // strobes and handshakes, all active low
  logic valid_out_n;
  logic valid_in_n;
  logic write_ready_n;
  logic read_ready_n;
  logic external_request_n;
  logic bus_release_n;

  // undriven bus reads as zero
  assign shared_addr_data_bus = dev_oe ? dev_ad :
                                (agt_oe ? agt_ad : '0);
  assign command_bus = dev_oe ? dev_cmd : (agt_oe ? agt_cmd : '0);

  // device end
  modport dev (
    input clk,
    output dev_ad, dev_cmd, dev_oe, valid_out_n, bus_release_n,
    input shared_addr_data_bus, command_bus, valid_in_n,
    input write_ready_n, read_ready_n, external_request_n
  );
  // external agent end
  modport agt (
    input clk,
    output agt_ad, agt_cmd, agt_oe, valid_in_n,
    output write_ready_n, read_ready_n, external_request_n,
    input shared_addr_data_bus, command_bus, valid_out_n, bus_release_n
  );
endinterface : sbw_bus_if

// File: hdl/sbw_delay.sv
// Purpose: fixed delay line of flip-flops
// Assumes: input is on the same clock
// Notes: reset value is a parameter so idle-high strobes delay cleanly
module sbw_delay #(
  parameter int W = 1,
  parameter int DEPTH = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // shift stages
  logic [W-1:0] stage [DEPTH];

  // shift one place per clock
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
        stage[i] <= INIT;
    end
    else
    begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++)
        stage[i] <= stage[i-1];
    end
  end

  assign dout = stage[DEPTH-1];
endmodule : sbw_delay

// File: hdl/sbw_device.sv
// Purpose: device end of the shared system bus (writes, external requests)
// Assumes: agent keeps its own timing; one master clock
// Notes: outputs toward the bus are registered from next_ values
// Overview of operation
// - legacy write: address, data, two dummy cycles
// - issue only if write ready low two earlier
// - reissue mode retries if ready high at address
// - pipeline mode drops the dummy cycles
// - agent accepts one more write after stall unless reissue
// - block write: command, data beats, last final
// - block writes share the single-write mode
// - agent requests only in slave state
// - agent drops request two cycles after release
// - agent holds request low for request series
// - external requests win; finish current first
// - release low one cycle, then float buses
// - agent drives two cycles after release, floats after
// - device drives again one cycle after float
// - external read and response are indivisible
// - agent read: command, address, then float
// - read answer: final response identifier, stay master
// - read answer carries error bit, undefined data
// - null request returns interface to master
// - external write: command, data, final, then master
// - external transfers are exactly one word
// - mode field bits two to one, reset legacy
module sbw_device (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus side
  sbw_bus_if.dev bus,
  // configuration
  input wire logic [sbw_pkg::CFG_W-1:0] interface_config_register,
  // processor write requests
  input wire logic wr_req,
  input wire logic [sbw_pkg::AD_W-1:0] wr_addr,
  input wire logic [sbw_pkg::LEN_W-1:0] wr_len,
  input wire logic [sbw_pkg::AD_W-1:0] wr_data,
  output logic wr_ack,
  output logic wr_data_take,
  // external requests seen
  output logic ext_wr_valid,
  output logic [sbw_pkg::AD_W-1:0] ext_wr_addr,
  output logic [sbw_pkg::AD_W-1:0] ext_wr_data,
  output logic ext_rd_valid,
  output logic [sbw_pkg::AD_W-1:0] ext_rd_addr,
  // ownership
  output logic is_master
);
  // one-hot states
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_ADDR = 10'h002,
    S_DATA = 10'h004,
    S_GAP = 10'h008,
    S_REL = 10'h010,
    S_SLAVE = 10'h020,
    S_SWDATA = 10'h040,
    S_TURN = 10'h080,
    S_RTURN = 10'h100,
    S_RESP = 10'h200
  } sbw_dev_state_type;

  sbw_dev_state_type state, next_state; // bus owner sequencer
  sbw_pkg::sbw_wmode_type mode; // flow-control mode in force
  logic [sbw_pkg::LEN_W-1:0] len, next_len; // words in current write
  logic [sbw_pkg::LEN_W-1:0] beat, next_beat; // data beat index
  logic [1:0] gap, next_gap; // dummy cycles left
  logic [sbw_pkg::AD_W-1:0] ad, next_ad; // registered bus data
  logic [sbw_pkg::CMD_W-1:0] cmd, next_cmd; // registered command
  logic oe, next_oe; // registered bus enable
  logic vout_n, next_vout_n; // registered valid strobe
  logic rel_n, next_rel_n; // registered release strobe
  logic wr_ready_old; // write ready from the previous cycle
  logic ext_want; // agent asks for the bus
  logic legacy; // dummy cycles needed
  logic start_ok; // new address cycle may follow
  logic last_beat; // current data beat is final
  logic in_valid; // agent cycle valid
  logic [sbw_pkg::CMD_W-1:0] in_cmd; // agent command
  logic [sbw_pkg::CMD_W-1:0] wcmd; // write command word

  // write ready one cycle back, two back from the next address cycle
  sbw_delay #(
    .W(1),
    .DEPTH(sbw_pkg::WRITE_READY_LAG - 1),
    .INIT(1'b1)
  ) sbw_delay_i (
    .clk(clk),
    .rstn(rstn),
    .din(bus.write_ready_n),
    .dout(wr_ready_old)
  );

  // decodes
  assign ext_want = !bus.external_request_n;
  assign in_valid = !bus.valid_in_n;
  assign in_cmd = bus.command_bus;
  assign wcmd = sbw_pkg::mk_cmd(sbw_pkg::CODE_WRITE);
  assign legacy = (mode != sbw_pkg::WMODE_PIPE) &&
                  (mode != sbw_pkg::WMODE_REISSUE);
  assign start_ok = wr_req && !wr_ready_old && !ext_want;
  assign last_beat = (sbw_pkg::LEN_W'(beat + 1'b1) >= len);
  assign is_master = !(state inside {S_SLAVE, S_SWDATA, S_TURN, S_RTURN});

  // next state and registered bus outputs
  always_comb
  begin
    next_state = state;
    next_len = len;
    next_beat = beat;
    next_gap = gap;
    next_ad = '0;
    next_cmd = '0;
    next_oe = oe;
    next_vout_n = 1'b1;
    next_rel_n = 1'b1;
    wr_ack = 1'b0;
    wr_data_take = 1'b0;
    case (state)
      // master: idle, gap and data beats; external requests win once beats and gaps are done
      S_IDLE, S_GAP, S_DATA:
      begin
        next_oe = 1'b1;
        if (state == S_DATA && !last_beat)
        begin
          next_beat = sbw_pkg::LEN_W'(beat + 1'b1);
          next_ad = wr_data;
          next_cmd = sbw_pkg::mk_id(
            sbw_pkg::LEN_W'(beat + 2'd2) >= len, 1'b0, 1'b0);
          next_vout_n = 1'b0;
          wr_data_take = 1'b1;
        end
        else if (state == S_DATA && legacy)
        begin
          next_state = S_GAP;
          next_gap = 2'(sbw_pkg::DUMMY_CYCLES - 1);
        end
        else if (state == S_GAP && gap != 2'h0)
          next_gap = 2'(gap - 1'b1);
        else if (ext_want)
        begin
          next_state = S_REL;
          next_rel_n = 1'b0;
        end
        else if (start_ok)
        begin
          next_state = S_ADDR;
          next_ad = wr_addr;
          next_cmd = wcmd;
          next_vout_n = 1'b0;
        end
        else
          next_state = S_IDLE;
      end
      // address cycle on the bus
      S_ADDR:
      begin
        if (mode == sbw_pkg::WMODE_REISSUE && bus.write_ready_n)
          next_state = S_IDLE;
        else
        begin
          next_state = S_DATA;
          next_len = wr_len;
          next_beat = '0;
          next_ad = wr_data;
          next_cmd = sbw_pkg::mk_id(wr_len <= 4'h1, 1'b0, 1'b0);
          next_vout_n = 1'b0;
          wr_ack = 1'b1;
          wr_data_take = 1'b1;
        end
      end
      S_REL:
      begin
        next_state = S_SLAVE;
        next_oe = 1'b0;
      end
      // slave: wait for the agent's request cycle
      S_SLAVE:
      begin
        if (in_valid && sbw_pkg::is_code(in_cmd, sbw_pkg::CODE_READ))
          next_state = S_RTURN;
        else if (in_valid &&
                 sbw_pkg::is_code(in_cmd, sbw_pkg::CODE_WRITE))
          next_state = S_SWDATA;
        else if (in_valid &&
                 sbw_pkg::is_code(in_cmd, sbw_pkg::CODE_NULL))
          next_state = S_TURN;
      end
      // single data word then hand back
      S_SWDATA:
      begin
        if (in_valid && in_cmd[sbw_pkg::CMD_DATA_BIT])
          next_state = S_TURN;
      end
      // drive again one cycle after float
      S_TURN:
      begin
        next_state = S_IDLE;
        next_oe = 1'b1;
      end
      // read answer follows with nothing between
      S_RTURN:
      begin
        next_state = S_RESP;
        next_oe = 1'b1;
        next_cmd = sbw_pkg::mk_id(1'b1, 1'b1, 1'b1);
        next_vout_n = 1'b0;
      end
      S_RESP:
      begin
        next_state = S_IDLE;
        next_oe = 1'b1;
      end
      default:
      begin
        next_state = S_IDLE;
        next_oe = 1'b1;
      end
    endcase
  end

  // sequencer and bus output registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // start as master driving the buses
      state <= S_IDLE;
      oe <= 1'b1;
      vout_n <= 1'b1;
      rel_n <= 1'b1;
      ad <= '0;
      cmd <= '0;
      len <= '0;
      beat <= '0;
      gap <= '0;
    end
    else
    begin
      state <= next_state;
      oe <= next_oe;
      vout_n <= next_vout_n;
      rel_n <= next_rel_n;
      ad <= next_ad;
      cmd <= next_cmd;
      len <= next_len;
      beat <= next_beat;
      gap <= next_gap;
    end
  end

  // mode register, loaded only between writes
  always_ff @(posedge clk)
  begin
    if (!rstn)
      mode <= sbw_pkg::sbw_wmode_type'(sbw_pkg::CFG_MODE_RESET);
    else if (state == S_IDLE)
      mode <= sbw_pkg::sbw_wmode_type'(interface_config_register[
        sbw_pkg::CFG_MODE_MSB:sbw_pkg::CFG_MODE_LSB]);
  end

  // capture of external requests for the user side
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ext_wr_valid <= 1'b0;
      ext_wr_addr <= '0;
      ext_wr_data <= '0;
      ext_rd_valid <= 1'b0;
      ext_rd_addr <= '0;
    end
    else
    begin
      ext_wr_valid <= (state == S_SWDATA) && in_valid &&
                      in_cmd[sbw_pkg::CMD_DATA_BIT];
      ext_rd_valid <= (state == S_SLAVE) && in_valid &&
                      sbw_pkg::is_code(in_cmd, sbw_pkg::CODE_READ);
      if (state == S_SLAVE && in_valid)
      begin
        ext_wr_addr <= bus.shared_addr_data_bus;
        ext_rd_addr <= bus.shared_addr_data_bus;
      end
      if (state == S_SWDATA && in_valid)
        ext_wr_data <= bus.shared_addr_data_bus;
    end
  end

  // bus drivers
  assign bus.dev_ad = ad;
  assign bus.dev_cmd = cmd;
  assign bus.dev_oe = oe;
  assign bus.valid_out_n = vout_n;
  assign bus.bus_release_n = rel_n;
endmodule : sbw_device

// File: hdl/sbw_agent.sv
// Purpose: external agent end of the shared system bus
// Assumes: device end follows the release and write timing
// Notes: a series flag keeps the bus request asserted between requests
module sbw_agent (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus side
  sbw_bus_if.agt bus,
  // external request port
  input wire logic op_req,
  input wire logic [2:0] op_code,
  input wire logic [sbw_pkg::AD_W-1:0] op_addr,
  input wire logic [sbw_pkg::AD_W-1:0] op_data,
  input wire logic op_series,
  output logic op_ack,
  output logic [sbw_pkg::AD_W-1:0] rd_data,
  output logic rd_err,
  // processor write sink
  input wire logic wr_stall,
  input wire logic reissue_mode,
  output logic dev_wr_valid,
  output logic dev_wr_is_addr,
  output logic dev_wr_final,
  output logic [sbw_pkg::AD_W-1:0] dev_wr_word
);
  // one-hot states
  typedef enum logic [5:0] {
    A_IDLE = 6'h01,
    A_REQ = 6'h02,
    A_WAIT = 6'h04,
    A_ADDR = 6'h08,
    A_DATA = 6'h10,
    A_RDWAIT = 6'h20
  } sbw_agt_state_type;

  sbw_agt_state_type state; // request sequencer
  logic [2:0] code; // latched request code
  logic [sbw_pkg::AD_W-1:0] data; // latched write word
  logic series; // keep request asserted
  logic wr_ok; // device address cycle counts
  logic out_valid; // device cycle valid
  logic [sbw_pkg::CMD_W-1:0] out_cmd; // device command

  assign out_valid = !bus.valid_out_n;
  assign out_cmd = bus.command_bus;
  // read requests are always welcome here
  assign bus.read_ready_n = 1'b0;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= A_IDLE;
      code <= sbw_pkg::CODE_NULL;
      data <= '0;
      series <= 1'b0;
      bus.agt_ad <= '0;
      bus.agt_cmd <= '0;
      bus.agt_oe <= 1'b0;
      bus.valid_in_n <= 1'b1;
      bus.external_request_n <= 1'b1;
      op_ack <= 1'b0;
      rd_data <= '0;
      rd_err <= 1'b0;
    end
    else
    begin
      op_ack <= 1'b0;
      bus.valid_in_n <= 1'b1;
      case (state)
        // ask for the bus
        A_IDLE:
        begin
          if (op_req)
          begin
            state <= A_REQ;
            bus.external_request_n <= 1'b0;
          end
        end
        // wait for the release pulse
        A_REQ:
        begin
          if (!bus.bus_release_n)
            state <= A_WAIT;
        end
        // latch request; null when series has nothing left
        A_WAIT:
        begin
          state <= A_ADDR;
          code <= op_req ? op_code : sbw_pkg::CODE_NULL;
          data <= op_data;
          series <= op_req && op_series;
          bus.agt_oe <= 1'b1;
          bus.agt_ad <= op_req ? op_addr : '0;
          bus.agt_cmd <= sbw_pkg::mk_cmd(op_req ? op_code :
                                         sbw_pkg::CODE_NULL);
          bus.valid_in_n <= 1'b0;
          bus.external_request_n <= op_req && op_series ? 1'b0 : 1'b1;
        end
        // one request cycle done
        A_ADDR:
        begin
          if (code == sbw_pkg::CODE_WRITE)
          begin
            state <= A_DATA;
            bus.agt_ad <= data;
            bus.agt_cmd <= sbw_pkg::mk_id(1'b1, 1'b0, 1'b0);
            bus.valid_in_n <= 1'b0;
          end
          else
          begin
            state <= (code == sbw_pkg::CODE_READ) ? A_RDWAIT :
                     (series ? A_REQ : A_IDLE);
            bus.agt_oe <= 1'b0;
            op_ack <= (code != sbw_pkg::CODE_READ);
          end
        end
        A_DATA:
        begin
          state <= series ? A_REQ : A_IDLE;
          bus.agt_oe <= 1'b0;
          op_ack <= 1'b1;
        end
        A_RDWAIT:
        begin
          if (out_valid && out_cmd[sbw_pkg::CMD_DATA_BIT])
          begin
            state <= series ? A_REQ : A_IDLE;
            rd_data <= bus.shared_addr_data_bus;
            rd_err <= out_cmd[sbw_pkg::ID_ERR_BIT];
            op_ack <= 1'b1;
          end
        end
        default:
          state <= A_IDLE;
      endcase
    end
  end

  // accept writes after stall unless reissue
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bus.write_ready_n <= 1'b1;
      wr_ok <= 1'b0;
      dev_wr_valid <= 1'b0;
      dev_wr_is_addr <= 1'b0;
      dev_wr_final <= 1'b0;
      dev_wr_word <= '0;
    end
    else
    begin
      // ready level leads the address by two
      bus.write_ready_n <= wr_stall;
      dev_wr_valid <= 1'b0;
      if (out_valid && sbw_pkg::is_code(out_cmd, sbw_pkg::CODE_WRITE))
      begin
        // in reissue mode the address counts only with ready low; otherwise always
        wr_ok <= !reissue_mode || !bus.write_ready_n;
        dev_wr_valid <= !reissue_mode || !bus.write_ready_n;
        dev_wr_is_addr <= 1'b1;
        dev_wr_final <= 1'b0;
        dev_wr_word <= bus.shared_addr_data_bus;
      end
      else if (out_valid && out_cmd[sbw_pkg::CMD_DATA_BIT] &&
               !out_cmd[sbw_pkg::ID_RESP_BIT])
      begin
        dev_wr_valid <= wr_ok;
        dev_wr_is_addr <= 1'b0;
        dev_wr_final <= out_cmd[sbw_pkg::ID_FINAL_BIT];
        dev_wr_word <= bus.shared_addr_data_bus;
      end
    end
  end
endmodule : sbw_agent

// File: dv/sbw_chk.sv
// Purpose: protocol checks on the shared bus between the two ends
// Assumes: inputs are the interface signals, one master clock
// Notes: instanced beside the interface by the bench top
module sbw_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // drive enables
  input wire logic dev_oe,
  input wire logic agt_oe,
  // strobes
  input wire logic valid_out_n,
  input wire logic valid_in_n,
  input wire logic write_ready_n,
  input wire logic bus_release_n,
  // command bus
  input wire logic [sbw_pkg::CMD_W-1:0] command_bus
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // command field and cycle decodes
  wire logic [3:0] top = command_bus[8:5];
  wire logic agt_v = agt_oe && !valid_in_n;
  wire logic is_wr = top == {1'b0, sbw_pkg::CODE_WRITE};
  wire logic dev_wr = dev_oe && !valid_out_n && is_wr;

  rel_one_a: assert property (
    $fell(bus_release_n) |=> bus_release_n) else $error("release too long");
  rel_float_a: assert property (
    !bus_release_n |=> !dev_oe) else $error("device drives after release");
  agt_start_a: assert property (
    $fell(bus_release_n) |-> ##2 agt_v) else $error("agent start late");
  no_clash_a: assert property (
    !(dev_oe && agt_oe)) else $error("both ends drive");
  wr_ready_a: assert property (
    dev_wr |-> !$past(write_ready_n, 2)) else $error("write not ready");
  rd_resp_a: assert property (
    agt_v && top == {1'b0, sbw_pkg::CODE_READ} |-> ##2
    (dev_oe && !valid_out_n && top == 4'hf)) else $error("bad read answer");
  null_back_a: assert property (
    agt_v && top == {1'b0, sbw_pkg::CODE_NULL} |-> ##2 dev_oe)
    else $error("null left slave");
  ext_wr_a: assert property (
    agt_v && is_wr |=> agt_v && top[3:2] == 2'h3 ##2 dev_oe)
    else $error("external write bad");
  float_back_a: assert property (
    $fell(agt_oe) |=> dev_oe) else $error("device not back");
  rst_master_a: assert property (
    $rose(rstn) |-> dev_oe) else $error("not master after reset");
  // main scenarios reached
  cover property (dev_wr);
  cover property (!bus_release_n);
  cover property (agt_v && top == {1'b0, sbw_pkg::CODE_READ});
endmodule : sbw_chk

// File: dv/sbw_tb_top.sv
// Purpose: both ends joined by the interface, driven from their user sides
// Assumes: inputs change at the falling edge
// Notes: address gaps are taken from the agent's write sink
module sbw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  // device user side
  logic [2:0] cfg = 3'h0;
  logic wr_req = 1'b0;
  logic [31:0] wr_addr = '0;
  logic [3:0] wr_len = 4'h1;
  logic [31:0] wr_data = 32'h1000;
  logic wr_ack, wr_data_take, ext_wr_valid, ext_rd_valid, is_master;
  logic [31:0] ext_wr_addr, ext_wr_data, ext_rd_addr;
  // agent user side
  logic op_req = 1'b0;
  logic [2:0] op_code = '0;
  logic [31:0] op_addr = '0;
  logic [31:0] op_data = '0;
  logic wr_stall = 1'b0;
  logic reissue_mode = 1'b0;
  logic op_series = 1'b0;
  logic op_ack, rd_err, dev_wr_valid, dev_wr_is_addr, dev_wr_final;
  logic [31:0] dev_wr_word;
  // bench state
  int errors = 0, checked = 0, cyc = 0, t_a = 0, gap = 0, nb = 0;
  logic [31:0] nxt = 32'h1000, ewa, ewd, era;
  logic [31:0] aq[$];
  logic take_d = 1'b0; // data take seen one cycle back

  always #10 clk = ~clk;

  sbw_bus_if sbw_bus_if_i (.clk);
  sbw_device sbw_device_i (.clk, .rstn, .bus(sbw_bus_if_i),
    .interface_config_register(cfg), .wr_req, .wr_addr, .wr_len, .wr_data,
    .wr_ack, .wr_data_take, .ext_wr_valid, .ext_wr_addr, .ext_wr_data,
    .ext_rd_valid, .ext_rd_addr, .is_master);
  sbw_agent sbw_agent_i (.clk, .rstn, .bus(sbw_bus_if_i), .op_req, .op_code,
    .op_addr, .op_data, .op_series, .op_ack, .rd_data(), .rd_err,
    .wr_stall, .reissue_mode, .dev_wr_valid, .dev_wr_is_addr, .dev_wr_final,
    .dev_wr_word);
  sbw_chk sbw_chk_i (.clk, .rstn, .dev_oe(sbw_bus_if_i.dev_oe),
    .agt_oe(sbw_bus_if_i.agt_oe), .valid_out_n(sbw_bus_if_i.valid_out_n),
    .valid_in_n(sbw_bus_if_i.valid_in_n),
    .write_ready_n(sbw_bus_if_i.write_ready_n),
    .bus_release_n(sbw_bus_if_i.bus_release_n),
    .command_bus(sbw_bus_if_i.command_bus));

  // compare and count
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // next data word after each take; stamp beats seen by the agent
  always @(negedge clk)
  begin
    cyc++;
    // advance only once the device has sampled the word
    if (take_d)
      wr_data <= wr_data + 32'h1;
    take_d <= wr_data_take;
    if (dev_wr_valid && dev_wr_is_addr)
    begin
      gap = cyc - t_a;
      t_a = cyc;
      nb = 0;
      chk("addr", dev_wr_word, aq.pop_front());
    end
    else if (dev_wr_valid)
    begin
      nb++;
      chk("data", dev_wr_word, nxt);
      nxt++;
      chk("final", dev_wr_final, nb == wr_len);
    end
    if (ext_wr_valid)
    begin
      ewa = ext_wr_addr;
      ewd = ext_wr_data;
    end
    if (ext_rd_valid)
      era = ext_rd_addr;
  end

  // raise a write request
  task go(input logic [31:0] a);
    wr_req = 1'b1;
    wr_addr = a;
    aq.push_back(a);
  endtask : go

  // bounded wait for the address accept
  task wt;
    int i;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (wr_ack !== 1'b1 && i < 40);
    chk("ack", wr_ack, 1'b1);
  endtask : wt

  // two writes back to back, then the address spacing
  task pair(input logic [2:0] c, input int g, input logic [3:0] l);
    cfg = c;
    reissue_mode = c[2:1] == 2'h3;
    wr_len = l;
    go(32'h100);
    wt();
    go(32'h200);
    wt();
    wr_req = 1'b0;
    repeat (14) @(negedge clk);
    chk("gap", gap, g);
    $display("pair %h done", c);
  endtask : pair

  // one external request, then ownership back
  task op(input logic [2:0] c, input logic [31:0] a);
    int i;
    op_req = 1'b1;
    op_code = c;
    op_addr = a;
    op_data = ~a;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (op_ack !== 1'b1 && i < 60);
    chk("op_ack", op_ack, 1'b1);
    op_req = 1'b0;
    repeat (8) @(negedge clk);
    chk("master", is_master, 1'b1);
    $display("op %h done", c);
  endtask : op

  // verdict and end of run
  task conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    int i;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("rst", is_master, 1'b1);
    pair(3'h0, 4, 4'h1);
    pair(3'h4, 2, 4'h1);
    pair(3'h6, 2, 4'h1);
    pair(3'h2, 4, 4'h1);
    pair(3'h4, 5, 4'h4);
    pair(3'h0, 7, 4'h4);
    wr_stall = 1'b1;
    repeat (3) @(negedge clk);
    i = t_a;
    go(32'h300);
    repeat (8) @(negedge clk);
    chk("stall", t_a, i);
    wr_stall = 1'b0;
    wt();
    wr_req = 1'b0;
    repeat (6) @(negedge clk);
    $display("stall done");
    op(sbw_pkg::CODE_WRITE, 32'h44);
    chk("ewa", ewa, 32'h44);
    chk("ewd", ewd, ~32'h44);
    op(sbw_pkg::CODE_READ, 32'h88);
    chk("era", era, 32'h88);
    chk("err", rd_err, 1'b1);
    op_series = 1'b1;
    op(sbw_pkg::CODE_WRITE, 32'h55);
    op_series = 1'b0;
    chk("ewa2", ewa, 32'h55);
    chk("ewd2", ewd, ~32'h55);
    op(sbw_pkg::CODE_NULL, 32'h0);
    conclude();
  end

  // watchdog
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
endmodule : sbw_tb_top
